// ==== bench/ext_memory_model.sv ====
// Transparent low-address latch of the external memory
`timescale 1ns/10ps
module ext_memory_model (
   input wire logic latch_strobe_in,
   input wire logic [7:0] addr_low_in,
   output logic [7:0] held_byte_out
);
   // Level-sensitive on purpose: an edge flop would hide a late address
   always_latch if (latch_strobe_in) held_byte_out <= addr_low_in;
endmodule

// ==== bench/external_bus_strobe_control_bench.sv ====
// Self-checking bench for the bus strobe controller
`timescale 1ns/10ps
module external_bus_strobe_control_bench;
   logic mclk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   bus_strobe_pkg::bus_req_t bus_req_in = '0;
   bus_strobe_pkg::strobe_cfg_t cfg_in = '0;
   logic data_move_start_in = 1'h0;
   logic [3:0] stretch_in = 4'h0;
   logic latch_strobe_out, program_store_strobe_n_out, addr_low_oe_out;
   logic data_move_busy_out, machine_cycle_start_out;
   logic [7:0] addr_low_out, held;
   int err_total = 0, tests_run = 0, ph = 0, cnt = 0, cyc = 0;
   int seed = 32'h40f72c20;
   bit chk_l = 0;
   wire en = !cfg_in.emi_reduce | cfg_in.latch_strobe_force_on | bus_req_in.ext_access;
   always #50 mclk_in = ~mclk_in;
   external_bus_strobe_control i_dut (.*);
   ext_memory_model i_mem (.latch_strobe_in(latch_strobe_out), .addr_low_in(addr_low_out),
      .held_byte_out(held));
   task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic close_out();
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic rst();
      sys_rst_in = 1'h1;
      cfg_in.traditional_mode = 1'h1;
      repeat (12) @(posedge mclk_in);
      @(negedge mclk_in) cmp("latch_rst", 8'h01, latch_strobe_out);
      @(posedge mclk_in) #1 sys_rst_in = 1'h0;
   endtask
   always @(posedge mclk_in) begin
      if (++cyc == 3000) begin
         err_total++;
         close_out();
      end
      ph = sys_rst_in ? 0 : (ph + 1) % 4;
      if (sys_rst_in) cnt = 0;
      else if (cnt > 0) cnt--;
      else if (data_move_start_in) cnt = 4 * ((stretch_in > 10 ? 10 : stretch_in) + 1);
   end
   // Negedge sampling keeps the compare clear of the posedge updates
   always @(negedge mclk_in) if (!sys_rst_in) begin
      cmp("cycle_start", ph == 0, machine_cycle_start_out);
      cmp("busy", cnt > 0, data_move_busy_out);
      if (chk_l && ph % 2 == 0)
         cmp("latch", en ? ph == 0 : cfg_in.traditional_mode, latch_strobe_out);
   end
   initial begin
      rst();
      for (int s = 0; s < 40; s++) begin
         if (s == 20) rst();
         cfg_in = 5'($random(seed));
         bus_req_in = 19'($random(seed));
         stretch_in = s < 4 ? 4'h0 : 4'($random(seed));
         data_move_start_in = 1'h1;
         @(posedge mclk_in) #1 data_move_start_in = 1'h0;
         repeat (4) @(posedge mclk_in);
         chk_l = cfg_in.page_mode == bus_strobe_pkg::PAGE_NONE;
         repeat (8) @(posedge mclk_in);
         #1 if (chk_l && bus_req_in.ext_access) cmp("addr", bus_req_in.addr[7:0], held);
         chk_l = 0;
      end
      close_out();
   end
endmodule
bind external_bus_strobe_control strobe_chk i_chk (.*);

// ==== bench/strobe_chk_properties.sv ====
// Port assertions for the bus strobe controller
`timescale 1ns/10ps
module strobe_chk (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire bus_strobe_pkg::bus_req_t bus_req_in,
   input wire bus_strobe_pkg::strobe_cfg_t cfg_in,
   input wire logic data_move_start_in,
   input wire logic [3:0] stretch_in,
   input wire logic latch_strobe_out,
   input wire logic program_store_strobe_n_out,
   input wire logic [7:0] addr_low_out,
   input wire logic addr_low_oe_out,
   input wire logic data_move_busy_out,
   input wire logic machine_cycle_start_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic pr, pe;
   bus_strobe_pkg::strobe_cfg_t pc;
   wire en = !cfg_in.emi_reduce | cfg_in.latch_strobe_force_on | bus_req_in.ext_access;
   wire n0 = cfg_in.page_mode == bus_strobe_pkg::PAGE_NONE;
   wire ok = !pr && pc == cfg_in && n0;
   wire pm1 = cfg_in.page_mode == bus_strobe_pkg::PAGE_ONE && bus_req_in.page_hit;
   wire psn = program_store_strobe_n_out;
   wire mcs = machine_cycle_start_out;
   wire bsy = data_move_busy_out;
   // Pulse decisions lag one edge, so guards use last edge's view
   always_ff @(posedge mclk_in) {pr, pe, pc} <= {sys_rst_in, en, cfg_in};
   a_program_store_strobe_n_idle: assert property (!$past(bus_req_in.code_fetch) |-> psn)
      else $error("idle strobe low");
   a_page_hold: assert property (pm1 && bus_req_in.code_fetch && !psn |=> !psn)
      else $error("page hold lost");
   a_cycle_len: assert property (mcs |=> !mcs [*3] ##1 mcs)
      else $error("bad cycle length");
   a_latch_phase: assert property (ok && en && pe |-> latch_strobe_out == mcs)
      else $error("bad latch phase");
   a_latch_quiet: assert property (pc == cfg_in && !en && !pe |-> latch_strobe_out == cfg_in.traditional_mode)
      else $error("bad quiet latch");
   a_page_width: assert property (@(negedge mclk_in) $past(pe) && $past(pc) == cfg_in &&
      !$past(sys_rst_in, 2) && $past(mcs) && !mcs |-> latch_strobe_out == n0)
      else $error("bad latch width");
   a_move_len: assert property (data_move_start_in && !bsy && stretch_in == 4'h0 |=>
      bsy [*4] ##1 !bsy)
      else $error("bad move length");
   a_addr_cap: assert property (ok && pe && mcs && bus_req_in.ext_access &&
      $stable(bus_req_in) |-> addr_low_out == bus_req_in.addr[7:0])
      else $error("bad low address");
   a_oe_window: assert property (addr_low_oe_out |-> mcs || $past(mcs))
      else $error("address drive outside window");
   c_move: cover property ($fell(bsy));
   c_quiet: cover property (!en && !pe && cfg_in.traditional_mode);
   c_hold: cover property (pm1 && !psn ##1 !psn);
endmodule

// ==== logic/bus_strobe_pkg.sv ====
// Constants and carrier types for the external bus strobe controller
package bus_strobe_pkg;
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam int PHASE_W = 2;
   localparam int STRETCH_W = 4;
   localparam int WAIT_W = 6;
   // One machine cycle spans four crystal clocks
   localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
   localparam logic [PHASE_W-1:0] PHASE_PROGRAM_STORE_STROBE_N_A = 2'h1;
   localparam logic [PHASE_W-1:0] PHASE_PROGRAM_STORE_STROBE_N_B = 2'h2;
   localparam logic [PHASE_W-1:0] PHASE_RST = 2'h0;
   localparam logic [STRETCH_W-1:0] STRETCH_MAX = 4'ha;
   localparam logic [WAIT_W-1:0] CLKS_PER_MC = 6'h04;
   localparam logic [WAIT_W-1:0] WAIT_RST = 6'h00;
   localparam logic [WAIT_W-1:0] WAIT_ONE = 6'h01;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      PAGE_NONE = 2'h0,
      PAGE_ONE = 2'h1,
      PAGE_TWO = 2'h2,
      PAGE_FOUR = 2'h3
   } page_mode_t;

   typedef struct packed {
      logic ext_access;
      logic code_fetch;
      logic page_hit;
      logic [ADDR_W-1:0] addr;
   } bus_req_t;

   typedef struct packed {
      logic emi_reduce;
      logic latch_strobe_force_on;
      logic traditional_mode;
      page_mode_t page_mode;
   } strobe_cfg_t;
endpackage

// ==== logic/external_bus_strobe_control.sv ====
// Strobe generator for the external program/data memory bus
`timescale 1ns/10ps
module external_bus_strobe_control #(
   parameter logic [bus_strobe_pkg::STRETCH_W-1:0] STRETCH_LIMIT = bus_strobe_pkg::STRETCH_MAX
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire bus_strobe_pkg::bus_req_t bus_req_in,
   input wire bus_strobe_pkg::strobe_cfg_t cfg_in,
   input wire logic data_move_start_in,
   input wire logic [bus_strobe_pkg::STRETCH_W-1:0] stretch_in,
   output logic latch_strobe_out,
   output logic program_store_strobe_n_out,
   output logic [bus_strobe_pkg::BYTE_W-1:0] addr_low_out,
   output logic addr_low_oe_out,
   output logic data_move_busy_out,
   output logic machine_cycle_start_out
);

   typedef enum logic [1:0] {
      MOVE_IDLE = 2'b01,
      MOVE_ACTIVE = 2'b10
   } move_state_t;

   logic [bus_strobe_pkg::PHASE_W-1:0] phase;
   logic ale_pos;
   logic ale_neg;
   logic ale_enable;
   logic ale_park_high;
   logic wide_pulse;
   logic program_store_strobe_n_window;
   logic page_hold;
   logic next_ale_pos;
   logic next_program_store_strobe_n_n;
   logic [bus_strobe_pkg::WAIT_W-1:0] wait_left;
   logic [bus_strobe_pkg::WAIT_W-1:0] next_wait;
   logic [bus_strobe_pkg::STRETCH_W-1:0] stretch_eff;
   move_state_t move_state;
   logic page_one;
   logic page_one_hit;

   // Page mode one is tested in both strobe paths
   function automatic logic is_page_one(input bus_strobe_pkg::page_mode_t mode);
      return mode == bus_strobe_pkg::PAGE_ONE;
   endfunction

   function automatic logic [bus_strobe_pkg::STRETCH_W-1:0] clamp_stretch(
      input logic [bus_strobe_pkg::STRETCH_W-1:0] req
   );
      logic [bus_strobe_pkg::STRETCH_W-1:0] lim;
      lim = STRETCH_LIMIT;
      if (req > lim) begin
         return lim;
      end
      return req;
   endfunction

   // Clocks a stretched move stays busy, less the final idle-test cycle
   function automatic logic [bus_strobe_pkg::WAIT_W-1:0] move_wait(
      input logic [bus_strobe_pkg::STRETCH_W-1:0] stretch
   );
      logic [bus_strobe_pkg::WAIT_W-1:0] cycles;
      cycles = (bus_strobe_pkg::WAIT_W)'(stretch) + bus_strobe_pkg::WAIT_ONE;
      return bus_strobe_pkg::CLKS_PER_MC * cycles - bus_strobe_pkg::WAIT_ONE;
   endfunction

   // Phase test shared by the latch strobe and machine-cycle start paths
   function automatic logic at_phase(
      input logic [bus_strobe_pkg::PHASE_W-1:0] now,
      input logic [bus_strobe_pkg::PHASE_W-1:0] want
   );
      return now == want;
   endfunction

   // Machine-cycle phase counter; phase 0 is the latch strobe phase
   // Free running: the phase and the latch strobe (unless emi_reduce parks it) keep their rhythm with no access
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         phase <= bus_strobe_pkg::PHASE_RST;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Combinational from the phase register; callers sample it on the edge
   assign machine_cycle_start_out = at_phase(phase, bus_strobe_pkg::PHASE_RST);

   // Strobe runs during accesses whatever the force-on bit says
   assign ale_enable = bus_req_in.ext_access
      | cfg_in.latch_strobe_force_on
      | ~cfg_in.emi_reduce;
   assign ale_park_high = cfg_in.traditional_mode & cfg_in.emi_reduce;
   // Only page mode none gets the falling-edge stretch to 1.5 clocks
   assign wide_pulse = (cfg_in.page_mode == bus_strobe_pkg::PAGE_NONE);
   assign page_one = is_page_one(cfg_in.page_mode);
   // A hit in page mode one reuses the latched low byte
   assign page_one_hit = page_one & bus_req_in.page_hit;

   always_comb begin
      next_ale_pos = 1'b0;
      if (sys_rst_in) begin
         next_ale_pos = cfg_in.traditional_mode;
      end else if (ale_enable) begin
         next_ale_pos = at_phase(phase, bus_strobe_pkg::PHASE_LAST);
         if (page_one_hit && bus_req_in.ext_access) begin
            next_ale_pos = 1'b0;
         end
      end else begin
         next_ale_pos = ale_park_high;
      end
   end

   always_ff @(posedge mclk_in) begin
      ale_pos <= next_ale_pos;
   end

   // Falling-edge stretch adds the half clock that makes 1.5 clocks
   // Reset clears it so the strobe shows only the reset level
   always_ff @(negedge mclk_in) begin
      if (sys_rst_in) begin
         ale_neg <= 1'b0;
      end else begin
         ale_neg <= ale_pos & (wide_pulse | ~ale_enable);
      end
   end

   // The OR of two flops is the only way to get a half-clock width
   assign latch_strobe_out = ale_pos | ale_neg;

   // Low address byte stands on the port while the strobe is high and
   // past its falling edge, where the outside latch closes on it
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         addr_low_out <= bus_strobe_pkg::BYTE_RST;
         addr_low_oe_out <= 1'b0;
      end else if (phase == bus_strobe_pkg::PHASE_LAST && bus_req_in.ext_access) begin
         addr_low_out <= bus_req_in.addr[bus_strobe_pkg::BYTE_W-1:0];
         addr_low_oe_out <= 1'b1;
      // Port released after phase 1 so data can turn around
      end else if (phase == bus_strobe_pkg::PHASE_PROGRAM_STORE_STROBE_N_A) begin
         addr_low_oe_out <= 1'b0;
      end
   end

   // Program strobe low in phases 2 and 3 of a fetch cycle
   assign program_store_strobe_n_window = (phase == bus_strobe_pkg::PHASE_PROGRAM_STORE_STROBE_N_A) |
                        (phase == bus_strobe_pkg::PHASE_PROGRAM_STORE_STROBE_N_B);
   // Hold needs the strobe already low, so a miss always reopens a pulse
   assign page_hold = page_one_hit & ~program_store_strobe_n_out;

   always_comb begin
      next_program_store_strobe_n_n = 1'b1;
      if (!sys_rst_in && bus_req_in.code_fetch) begin
         if (page_hold) begin
            next_program_store_strobe_n_n = 1'b0;
         end else begin
            next_program_store_strobe_n_n = ~program_store_strobe_n_window;
         end
      end
   end

   // Registered so the pin never glitches between phases
   always_ff @(posedge mclk_in) begin
      program_store_strobe_n_out <= next_program_store_strobe_n_n;
   end

   // Stretch values above the limit are clamped rather than wrapped
   assign stretch_eff = clamp_stretch(stretch_in);

   always_comb begin
      next_wait = wait_left - bus_strobe_pkg::WAIT_ONE;
      if (move_state == MOVE_IDLE) begin
         next_wait = move_wait(stretch_eff);
      end
   end

   // A start while busy is ignored; the caller must wait for idle
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         move_state <= MOVE_IDLE;
         wait_left <= bus_strobe_pkg::WAIT_RST;
      end else begin
         case (move_state)
            MOVE_IDLE: begin
               if (data_move_start_in) begin
                  move_state <= MOVE_ACTIVE;
                  wait_left <= next_wait;
               end
            end
            MOVE_ACTIVE: begin
               if (wait_left == bus_strobe_pkg::WAIT_RST) begin
                  move_state <= MOVE_IDLE;
               end else begin
                  wait_left <= next_wait;
               end
            end
            default: begin
               move_state <= MOVE_IDLE;
            end
         endcase
      end
   end

   // Busy comes from the state register, so it is glitch free
   assign data_move_busy_out = (move_state == MOVE_ACTIVE);

endmodule
